// [hw/fabo_top.sv]
// Output side of an 8-bit sampling converter board
//
// What this block does
// RQ1 - Convert on start rising edge; pulses >=10 ns; a pulse here must be high at a 50 ns core clock edge
// RQ2 - Three start pulses before output is valid
// RQ3 - Result stable at end-of-conversion falling edge
// RQ4 - End-of-conversion delay: four 6 ns steps, default zero; each step here is one 50 ns core clock
// RQ5 - Default coding offset binary, selects at one
// RQ6 - Selects at zero give other output codings
// RQ7 - Unipolar: step number as straight binary
// RQ8 - Bipolar: offset binary, zero gives 10000000
// RQ9 - Sustain start rate; partner keeps within it; here at most one start per two 50 ns core clocks
// RQ10 - Top select flips MSB, low select rest
module fabo_top
  import fabo_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_start_convert,
  input  wire logic [DATA_W-1:0] i_step,
  input  wire logic              i_top_bit_invert_select,
  input  wire logic              i_low_bits_invert_select,
  input  wire logic [1:0]        i_eoc_delay_select,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_eoc,
  output logic                   o_valid
);

  //////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Start edge and pipeline

  fabo_state_t       state_q,  state_d;
  logic [1:0]        fill_q,   fill_d;
  logic              sc_q,     sc_d;
  logic [DATA_W-1:0] st1_q,    st1_d;
  logic [DATA_W-1:0] st2_q,    st2_d;
  logic [DATA_W-1:0] st3_q,    st3_d;
  logic              req_q,    req_d;
  logic [DATA_W-1:0] code_mask;
  logic              sc_rise;

  assign sc_rise = i_start_convert & ~sc_q; // [RQ1]

  // Inversion mask from the two coding selects
  always_comb begin
    code_mask = '0;
    if (i_top_bit_invert_select == SEL_INVERT) begin
      code_mask = code_mask | TOP_MASK; // [RQ10]
    end
    if (i_low_bits_invert_select == SEL_INVERT) begin
      code_mask = code_mask | LOW_MASK; // [RQ10]
    end
  end

  always_comb begin
    state_d = state_q;
    fill_d  = fill_q;
    sc_d    = i_start_convert;
    st1_d   = st1_q;
    st2_d   = st2_q;
    st3_d   = st3_q;
    req_d   = 1'b0;
    // Every rising edge is taken; no busy window
    if (sc_rise) begin // [RQ9]
      st1_d = i_step;                 // [RQ1]
      st2_d = st1_q;
      st3_d = st2_q ^ code_mask;      // [RQ5] [RQ6] [RQ7] [RQ8]
      case (state_q)
        ST_FILL: begin
          if (fill_q == FILL_LAST) begin
            state_d = ST_RUN;         // [RQ2]
            req_d   = 1'b1;
          end else begin
            fill_d  = fill_q + 2'h1;
          end
        end
        ST_RUN: begin
          req_d = 1'b1;
        end
        default: begin
          state_d = ST_FILL;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_FILL;
      fill_q  <= FILL_RST;
      sc_q    <= 1'b0;
      st1_q   <= DATA_RST;
      st2_q   <= DATA_RST;
      st3_q   <= DATA_RST;
      req_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      fill_q  <= fill_d;
      sc_q    <= sc_d;
      st1_q   <= st1_d;
      st2_q   <= st2_d;
      st3_q   <= st3_d;
      req_q   <= req_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // End-of-conversion delay and outputs

  fabo_dly_if dl ();

  assign dl.in_stb  = req_q;
  assign dl.in_data = st3_q;
  assign dl.sel     = i_eoc_delay_select;

  fabo_eoc_delay u_eoc_delay (
    .i_clk   (i_core_clk),
    .i_rst_n (rst_sync_q),
    .dl      (dl.dly)
  );

  logic [DATA_W-1:0] data_q,  data_d;
  logic              eoc_q,   eoc_d;
  logic              valid_q, valid_d;

  // Word loads with the strobe and holds past its falling edge
  always_comb begin
    eoc_d   = dl.out_stb;                        // [RQ4]
    data_d  = dl.out_stb ? dl.out_data : data_q; // [RQ3]
    valid_d = valid_q | dl.out_stb;              // [RQ2]
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      data_q  <= DATA_RST;
      eoc_q   <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      data_q  <= data_d;
      eoc_q   <= eoc_d;
      valid_q <= valid_d;
    end
  end

  assign o_data  = data_q;
  assign o_eoc   = eoc_q;
  assign o_valid = valid_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!rst_sync_q);

  AST_RISE_CAPTURE: assert property ( // [RQ1]
    sc_rise |=> (st1_q == $past(i_step)) && (st2_q == $past(st1_q)))
    else $error("Sample not captured on start rising edge");

  AST_NO_RISE_HOLD: assert property ( // [RQ1]
    !sc_rise |=> $stable(st1_q) && $stable(st3_q) && !req_q)
    else $error("Pipeline moved without a start edge");

  AST_FILL_SILENT: assert property ( // [RQ2]
    (state_q == ST_FILL && fill_q != FILL_LAST && sc_rise)
      |=> !req_q && state_q == ST_FILL)
    else $error("Result offered before third start pulse");

  AST_THIRD_PULSE: assert property ( // [RQ2]
    (state_q == ST_FILL && fill_q == FILL_LAST && sc_rise)
      |=> req_q && state_q == ST_RUN)
    else $error("Third start pulse did not release output");

  AST_EOC_AFTER_FILL: assert property ( // [RQ2]
    o_eoc |-> o_valid && state_q == ST_RUN)
    else $error("End of conversion while pipeline filling");

  AST_DATA_AT_FALL: assert property ( // [RQ3]
    $rose(o_eoc) |=> !o_eoc && $stable(o_data))
    else $error("Data changed at end-of-conversion fall");

  AST_EOC_NO_DELAY: assert property ( // [RQ4]
    (sc_rise && state_q == ST_RUN && i_eoc_delay_select == 2'h0)
      ##1 (i_eoc_delay_select == 2'h0) |=> o_eoc)
    else $error("Zero delay setting did not give strobe in 2 cycles");

  AST_EOC_MAX_DELAY: assert property ( // [RQ4]
    (sc_rise && state_q == ST_RUN)
      ##0 (i_eoc_delay_select == 2'h3) [*5] |=> o_eoc)
    else $error("Longest delay setting did not give strobe in 5 cycles");

  AST_CODE_DEFAULT: assert property ( // [RQ5]
    (sc_rise && i_top_bit_invert_select && i_low_bits_invert_select)
      |=> st3_q == $past(st2_q))
    else $error("Default coding is not the plain step number");

  AST_CODE_TWOS: assert property ( // [RQ10]
    (sc_rise && !i_top_bit_invert_select && i_low_bits_invert_select)
      |=> st3_q == ($past(st2_q) ^ TOP_MASK))
    else $error("Two's complement coding wrong");

  AST_CODE_NEG: assert property ( // [RQ6]
    (sc_rise && !i_top_bit_invert_select && !i_low_bits_invert_select)
      |=> st3_q == ~$past(st2_q))
    else $error("Negative true coding wrong");

  AST_RESULT_PATH: assert property ( // [RQ7]
    (sc_rise && state_q == ST_RUN && i_eoc_delay_select == 2'h0)
      ##1 (i_eoc_delay_select == 2'h0) |=> o_data == $past(st3_q))
    else $error("Output word is not the coded pipeline result");

  CVR_FIRST_VALID: cover property ($rose(o_valid));
  CVR_MAX_DELAY: cover property (
    o_eoc && i_eoc_delay_select == 2'h3);
  CVR_TWOS: cover property (
    o_eoc && !i_top_bit_invert_select && i_low_bits_invert_select);
  CVR_BACK_TO_BACK: cover property (sc_rise ##2 sc_rise);

endmodule : fabo_top

// [shared/fabo_pkg.sv]
// Constants and types shared by the converter output logic
package fabo_pkg;

  // Data path
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PIPE_PULSES = 3;
  localparam logic [1:0]  FILL_LAST   = 2'h2;
  localparam logic [1:0]  FILL_RST    = 2'h0;
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic [7:0]  TOP_MASK    = 8'h80;
  localparam logic [7:0]  LOW_MASK    = 8'h7f;

  // Coding selects: 1 keeps the bits, 0 inverts them
  localparam logic        SEL_KEEP    = 1'b1;
  localparam logic        SEL_INVERT  = 1'b0;

  // Core clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Start-convert pulse: least width, rounded up, at least one cycle
  localparam int unsigned SC_MIN_WIDTH_NS = 10;
  localparam int unsigned SC_MIN_CYC_RAW  =
    (SC_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SC_MIN_CYC      =
    (SC_MIN_CYC_RAW < 1) ? 1 : SC_MIN_CYC_RAW;

  // End-of-conversion delay step, rounded down, at least one cycle
  localparam int unsigned EOC_STEP_NS      = 6;
  localparam int unsigned EOC_STEP_CYC_RAW = EOC_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned EOC_STEP_CYC     =
    (EOC_STEP_CYC_RAW < 1) ? 1 : EOC_STEP_CYC_RAW;
  localparam int unsigned EOC_STEPS        = 4;
  localparam int unsigned EOC_MAX_DLY      = (EOC_STEPS - 1) * EOC_STEP_CYC;
  localparam logic [1:0]  EOC_SEL_RST      = 2'h0;

  // Supported start-convert rates
  localparam int unsigned SC_RATE_MIN_MHZ = 30;
  localparam int unsigned SC_RATE_TYP_MHZ = 40;

  // Pipeline fill state
  typedef enum logic [1:0] {
    ST_FILL = 2'b00,
    ST_RUN  = 2'b01
  } fabo_state_t;

endpackage : fabo_pkg

// [shared/fabo_dly_if.sv]
// Strobe and result word passed through the end-of-conversion delay
interface fabo_dly_if;
  import fabo_pkg::*;

  logic              in_stb;
  logic [DATA_W-1:0] in_data;
  logic [1:0]        sel;
  logic              out_stb;
  logic [DATA_W-1:0] out_data;

  modport src (output in_stb, output in_data, output sel,
               input  out_stb, input out_data);
  modport dly (input  in_stb, input in_data, input sel,
               output out_stb, output out_data);
endinterface : fabo_dly_if

// [hw/fabo_eoc_delay.sv]
// Selectable delay line for the end-of-conversion strobe and its word
module fabo_eoc_delay
  import fabo_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  fabo_dly_if.dly   dl
);

  logic [DATA_W:0] tap_q [EOC_MAX_DLY];
  logic [DATA_W:0] tap_d [EOC_MAX_DLY];
  logic [DATA_W:0] sel_word;

  always_comb begin
    tap_d[0] = {dl.in_stb, dl.in_data};
    for (int k = 1; k < EOC_MAX_DLY; k++) begin
      tap_d[k] = tap_q[k-1];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < EOC_MAX_DLY; k++) begin
        tap_q[k] <= {1'b0, DATA_RST};
      end
    end else begin
      for (int k = 0; k < EOC_MAX_DLY; k++) begin
        tap_q[k] <= tap_d[k];
      end
    end
  end

  // Step zero bypasses the line, each further step adds its cycles
  always_comb begin
    if (dl.sel == 2'h0) begin
      sel_word = {dl.in_stb, dl.in_data};
    end else begin
      sel_word = tap_q[int'(dl.sel) * EOC_STEP_CYC - 1]; // [RQ4]
    end
  end

  assign dl.out_stb  = sel_word[DATA_W];
  assign dl.out_data = sel_word[DATA_W-1:0];

endmodule : fabo_eoc_delay

// [test/fabo_capture_model.sv]
// Far-side capture logic latching each result on the strobe's trailing edge
module fabo_capture_model
  import fabo_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_eoc,
  input  wire logic              i_valid,
  output logic      [DATA_W:0]   o_word,
  output logic                   o_stb
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // Edge where the one-cycle strobe drops takes the word
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stb  <= 1'b0;
      o_word <= '0;
    end else begin
      o_stb <= i_eoc;
      if (i_eoc) begin
        o_word <= {i_valid, i_data};
      end
    end
  end
endmodule : fabo_capture_model

// [test/tb_top.sv]
// Self-checking bench for the converter output block
module tb_top
  import fabo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [DATA_W:0] word;
    int unsigned     cyc;
  } fabo_exp_t;

  localparam logic [7:0] BND [3] = '{8'h00, 8'h80, 8'hff};

  logic              clk, rst_n, start, top_sel, low_sel, stb, eoc, valid;
  logic [DATA_W-1:0] step, data;
  logic [1:0]        dly;
  logic [DATA_W:0]   word;
  logic [31:0]       rng;
  logic [DATA_W-1:0] hist [2];
  int unsigned       cyc, miscompares, checked, pulses;
  fabo_exp_t         exp_q [$];

  fabo_top dut_u (
    .i_core_clk               (clk),
    .i_rst_n                  (rst_n),
    .i_start_convert          (start),
    .i_step                   (step),
    .i_top_bit_invert_select  (top_sel),
    .i_low_bits_invert_select (low_sel),
    .i_eoc_delay_select       (dly),
    .o_data                   (data),
    .o_eoc                    (eoc),
    .o_valid                  (valid)
  );

  fabo_capture_model cap_u (
    .i_clk   (clk),
    .i_rst_n (rst_n),
    .i_data  (data),
    .i_eoc   (eoc),
    .i_valid (valid),
    .o_word  (word),
    .o_stb   (stb)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : next_rand

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checked++;
    if (seen !== expd) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask : check

  task automatic give_verdict();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // One-cycle start pulse, gap cycles from rise to next rise
  task automatic pulse(input logic [DATA_W-1:0] s, input int unsigned gap);
    fabo_exp_t e;
    @(negedge clk);
    start = 1'b1;
    step  = s;
    pulses++;
    if (pulses >= PIPE_PULSES) begin
      e.word = {1'b1, hist[0] ^ (top_sel ? 8'h00 : TOP_MASK)
                              ^ (low_sel ? 8'h00 : LOW_MASK)};
      e.cyc  = cyc + 3 + dly;
      exp_q.push_back(e);
    end
    hist[0] = hist[1];
    hist[1] = s;
    @(negedge clk);
    start = 1'b0;
    repeat (gap - 2) @(negedge clk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher
  always @(negedge clk) begin
    fabo_exp_t e;
    if (rst_n && stb) begin
      if (exp_q.size() == 0) begin
        check(32'(word), 32'hffff_ffff);
      end else begin
        e = exp_q.pop_front();
        check(32'(word), 32'(e.word));
        check(cyc, e.cyc);
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    rst_n       = 1'b0;
    start       = 1'b0;
    step        = 8'h00;
    top_sel     = SEL_KEEP;
    low_sel     = SEL_KEEP;
    dly         = EOC_SEL_RST;
    miscompares = 0;
    checked     = 0;
    pulses      = 0;
    rng         = 32'h0000_5dda; // Seed 24026
    hist        = '{default: '0};
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    pulse(8'h00, 2);
    pulse(8'h80, 3);
    repeat (4) @(negedge clk);
    check(32'({valid, data}), 32'h0);
    pulse(8'hff, 2);
    for (int k = 0; k < 16; k++) begin
      repeat (8) @(negedge clk);
      {top_sel, low_sel} = 2'(k);
      dly = 2'(k >> 2);
      for (int j = 0; j < 6; j++) begin
        rng = next_rand(rng);
        pulse((j < 3) ? BND[j] : rng[7:0], 2 + 32'(rng[8]));
      end
    end
    repeat (12) @(negedge clk);
    check(32'(exp_q.size()), 32'h0);
    give_verdict();
  end
endmodule : tb_top
